// ==== sbs_defs.svh ====
// constants for the sample burst serial master: fields, reset values, timing
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_SETUP_RESET    8'h00
`define SBS_BIT_RATE       0
`define SBS_BIT_SIZE       1
`define SBS_BIT_GAP        2
`define SBS_SUBSET_LO      3
`define SBS_SUBSET_HI      4
`define SBS_BIT_POL        5
`define SBS_ENABLE_BIT     6
`define SBS_CLK_PERIOD_PS  4000
`define SBS_HALF_8M_PS     62500
`define SBS_HALF_4M_PS     125000
`define SBS_HALF_CYC(ps)   (((ps) + `SBS_CLK_PERIOD_PS - 1) / `SBS_CLK_PERIOD_PS)
`define SBS_GAP_CYCLES     7
`define SBS_WORDS          16
`define SBS_PKG_WIDE       32
`define SBS_PKG_NARROW     8
`define SBS_WAVE_LAST      6
`define SBS_POWER_FIRST    7
`define SBS_NEUTRAL_SLOT   6
`define SBS_REACTIVE_FIRST 13
`define SBS_FIFO_DEPTH     4
`endif

// ==== sbs_pkg.sv ====
// types for the sample burst serial master
package sbs_pkg;
  typedef enum logic [1:0] {sbs_st_idle, sbs_st_shift, sbs_st_gap} sbs_state_t;
  typedef enum logic [1:0] {sbs_sub_all, sbs_sub_wave, sbs_sub_power, sbs_sub_rsvd} sbs_subset_t;
endpackage : sbs_pkg

// ==== sbs_serial_master.sv ====
// sample burst serial master with its word fifo
// What this block does
// - port disabled after reset until enable set
// - enable write of 1 ignored while four-wire port active
// - words are 24-bit samples sign extended to 32
// - full burst order: waves, neutral, va, watt, var
// - missing neutral or reactive slots send zero
// - port is master, drives clock, select, data
// - rate bit: 0 gives 8 MHz, 1 gives 4 MHz
// - data changes on falling edge, slave samples rising
// - package 32 or 8 bits, msb first
// - gap bit inserts seven clock cycles between packages
// - no gap: bits back to back, size ignored
// - subset 00 all, 01 waves, 10 powers
// - subset 11 behaves as 00
// - subset 01 sends seven current and voltage words
// - subset 10 sends nine power words
// - polarity 0: select low while shifting, else high
// - polarity 1: select high while shifting, else low (high while disabled)
// - setup bits 7:6 have no effect
// - data and select pins high after reset
// - burst per sample tick, long bursts every other
`timescale 1ns/1ps
`include "sbs_defs.svh"

// ****************************************
// word fifo
// ****************************************
module sbs_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sbs_fifo

// ****************************************
// serial master
// ****************************************
module sbs_serial_master #(
  parameter bit HAS_NEUTRAL  = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        setup_wr_in,
  input  wire logic [7:0]  setup_wdata_in,
  output logic      [7:0]  setup_rdata_out,
  input  wire logic        enable_wr_in,
  input  wire logic        enable_wdata_in,
  output logic             enable_rdata_out,
  input  wire logic        four_wire_active_in,
  input  wire logic        sample_tick_in,
  input  wire logic [23:0] phase_a_current_sample_in,
  input  wire logic [23:0] phase_a_voltage_sample_in,
  input  wire logic [23:0] phase_b_current_sample_in,
  input  wire logic [23:0] phase_b_voltage_sample_in,
  input  wire logic [23:0] phase_c_current_sample_in,
  input  wire logic [23:0] phase_c_voltage_sample_in,
  input  wire logic [23:0] neutral_current_sample_in,
  input  wire logic [23:0] phase_a_apparent_power_in,
  input  wire logic [23:0] phase_b_apparent_power_in,
  input  wire logic [23:0] phase_c_apparent_power_in,
  input  wire logic [23:0] phase_a_active_power_in,
  input  wire logic [23:0] phase_b_active_power_in,
  input  wire logic [23:0] phase_c_active_power_in,
  input  wire logic [23:0] phase_a_reactive_power_in,
  input  wire logic [23:0] phase_b_reactive_power_in,
  input  wire logic [23:0] phase_c_reactive_power_in,
  output logic             capture_serial_clock_out,
  output logic             capture_data_out,
  output logic             capture_select_out,
  output logic             burst_busy_out
);
  import sbs_pkg::*;

  localparam logic [5:0] HALF8  = 6'(`SBS_HALF_CYC(`SBS_HALF_8M_PS));
  localparam logic [5:0] HALF4  = 6'(`SBS_HALF_CYC(`SBS_HALF_4M_PS));
  localparam logic [3:0] W_LAST = 4'(`SBS_WORDS - 1);

  // ****************************************
  // setup and enable
  // ****************************************
  logic [5:0] setup;
  logic       enable;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      setup <= 6'(`SBS_SETUP_RESET);
    end else if (setup_wr_in) begin
      setup <= setup_wdata_in[5:0];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable <= 1'b0;
    end else if (enable_wr_in && !(enable_wdata_in && four_wire_active_in)) begin
      enable <= enable_wdata_in;
    end
  end

  assign setup_rdata_out  = {2'b00, setup};
  assign enable_rdata_out = enable;

  // ****************************************
  // snapshot and loader
  // ****************************************
  logic [23:0] live [`SBS_WORDS];
  logic [23:0] snap [`SBS_WORDS];
  logic [5:0]  cfg;
  logic        loading;
  logic [3:0]  load_idx;
  logic [3:0]  load_end;
  logic        busy;
  logic        start_burst;
  logic        zero_slot;
  logic [31:0] load_word;
  logic        f_in_ready;
  logic        f_out_valid;
  logic        f_pop;
  logic [32:0] f_out_data;
  sbs_subset_t subset;
  sbs_state_t  state;

  assign live[0]  = phase_a_current_sample_in;
  assign live[1]  = phase_a_voltage_sample_in;
  assign live[2]  = phase_b_current_sample_in;
  assign live[3]  = phase_b_voltage_sample_in;
  assign live[4]  = phase_c_current_sample_in;
  assign live[5]  = phase_c_voltage_sample_in;
  assign live[6]  = neutral_current_sample_in;
  assign live[7]  = phase_a_apparent_power_in;
  assign live[8]  = phase_b_apparent_power_in;
  assign live[9]  = phase_c_apparent_power_in;
  assign live[10] = phase_a_active_power_in;
  assign live[11] = phase_b_active_power_in;
  assign live[12] = phase_c_active_power_in;
  assign live[13] = phase_a_reactive_power_in;
  assign live[14] = phase_b_reactive_power_in;
  assign live[15] = phase_c_reactive_power_in;

  assign subset = sbs_subset_t'(setup[`SBS_SUBSET_HI:`SBS_SUBSET_LO]);
  // a tick while a long burst still runs is dropped, so it goes every other tick
  assign busy        = loading || (state != sbs_st_idle) || f_out_valid;
  assign start_burst = sample_tick_in && enable && !busy;
  assign burst_busy_out = busy;

  assign zero_slot = (!HAS_NEUTRAL && load_idx == 4'(`SBS_NEUTRAL_SLOT)) ||
                     (!HAS_REACTIVE && load_idx >= 4'(`SBS_REACTIVE_FIRST));
  assign load_word = zero_slot ? 32'h0000_0000 :
                     {{8{snap[load_idx][23]}}, snap[load_idx]};

  always_ff @(posedge clk_in) begin
    if (start_burst) begin
      snap <= live;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg      <= 6'(`SBS_SETUP_RESET);
      loading  <= 1'b0;
      load_idx <= 4'h0;
      load_end <= 4'h0;
    end else if (!enable) begin
      loading <= 1'b0;
    end else if (start_burst) begin
      cfg     <= setup; // config frozen for the whole burst
      loading <= 1'b1;
      case (subset)
        sbs_sub_wave: begin
          load_idx <= 4'h0;
          load_end <= 4'(`SBS_WAVE_LAST);
        end
        sbs_sub_power: begin
          load_idx <= 4'(`SBS_POWER_FIRST);
          load_end <= W_LAST;
        end
        default: begin
          load_idx <= 4'h0;
          load_end <= W_LAST;
        end
      endcase
    end else if (loading && f_in_ready) begin
      if (load_idx == load_end) loading <= 1'b0;
      else load_idx <= load_idx + 1'b1;
    end
  end

  sbs_fifo #(
    .WIDTH (33),
    .DEPTH (`SBS_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .flush_in      (!enable),
    .in_valid_in   (loading),
    .in_ready_out  (f_in_ready),
    .in_data_in    ({load_idx == load_end, load_word}),
    .out_valid_out (f_out_valid),
    .out_ready_in  (f_pop),
    .out_data_out  (f_out_data)
  );

  // ****************************************
  // shifter
  // ****************************************
  logic [5:0]  half;
  logic [5:0]  hcnt;
  logic [5:0]  bit_cnt;
  logic [5:0]  pkg_cnt;
  logic [5:0]  pkg_last;
  logic [2:0]  gap_cnt;
  logic [31:0] shreg;
  logic        last_word;
  logic        sclk;
  logic        data_q;
  logic        tick;
  logic        stall;
  logic        tick_ok;
  logic        pol;

  assign half     = cfg[`SBS_BIT_RATE] ? HALF4 : HALF8;
  assign pkg_last = cfg[`SBS_BIT_SIZE] ? 6'(`SBS_PKG_NARROW - 1) : 6'(`SBS_PKG_WIDE - 1);
  assign tick     = (state != sbs_st_idle) && (hcnt == half - 6'd1);
  // wait on a late word instead of sending a stale bit
  assign stall    = sclk && (state == sbs_st_shift) && (bit_cnt == 6'd0) && !f_out_valid;
  assign tick_ok  = tick && !stall;
  assign f_pop    = tick_ok && sclk && (state == sbs_st_shift) && (bit_cnt == 6'd0);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hcnt <= 6'd0;
    end else if (state == sbs_st_idle || tick_ok) begin
      hcnt <= 6'd0;
    end else if (!tick) begin
      hcnt <= hcnt + 6'd1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state     <= sbs_st_idle;
      sclk      <= 1'b1;
      data_q    <= 1'b1;
      shreg     <= 32'h0000_0000;
      bit_cnt   <= 6'd0;
      pkg_cnt   <= 6'd0;
      gap_cnt   <= 3'd0;
      last_word <= 1'b0;
    end else if (!enable) begin
      state  <= sbs_st_idle;
      sclk   <= 1'b1;
      data_q <= 1'b1;
    end else begin
      case (state)
        sbs_st_idle: begin
          sclk <= 1'b1;
          if (f_out_valid) begin
            state   <= sbs_st_shift;
            bit_cnt <= 6'd0;
            pkg_cnt <= 6'd0;
          end
        end
        sbs_st_shift: begin
          if (tick_ok && sclk) begin
            sclk <= 1'b0;
            if (bit_cnt == 6'd0) begin
              data_q    <= f_out_data[31];
              shreg     <= {f_out_data[30:0], 1'b0};
              last_word <= f_out_data[32];
              bit_cnt   <= 6'd31;
            end else begin
              data_q  <= shreg[31];
              shreg   <= {shreg[30:0], 1'b0};
              bit_cnt <= bit_cnt - 6'd1;
            end
          end else if (tick_ok) begin
            sclk <= 1'b1;
            if (bit_cnt == 6'd0 && last_word) begin
              state <= sbs_st_idle;
            end else if (cfg[`SBS_BIT_GAP] && pkg_cnt == pkg_last) begin
              state   <= sbs_st_gap;
              pkg_cnt <= 6'd0;
              gap_cnt <= 3'd0;
            end else begin
              // without gap the count only wraps and steers nothing
              pkg_cnt <= (pkg_cnt == pkg_last) ? 6'd0 : pkg_cnt + 6'd1;
            end
          end
        end
        sbs_st_gap: begin
          if (tick_ok) begin
            sclk <= !sclk;
            if (!sclk) begin
              if (gap_cnt == 3'(`SBS_GAP_CYCLES - 1)) state <= sbs_st_shift;
              else gap_cnt <= gap_cnt + 3'd1;
            end
          end
        end
        default: state <= sbs_st_idle;
      endcase
    end
  end

  // polarity follows the live bit at rest, the frozen one in a burst
  assign pol = (state == sbs_st_idle) ? setup[`SBS_BIT_POL] : cfg[`SBS_BIT_POL];
  assign capture_select_out = !enable ? 1'b1 :
                              (state == sbs_st_shift) ? pol : !pol;
  assign capture_serial_clock_out = sclk;
  assign capture_data_out         = data_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_disabled_pins;
    (!enable && !enable_wr_in) |=> capture_data_out && capture_select_out && capture_serial_clock_out;
  endproperty
  a_disabled_pins: assert property (p_disabled_pins) else $error("pins not high while disabled");

  property p_enable_ignored;
    (enable_wr_in && enable_wdata_in && four_wire_active_in && !enable) |=> !enable;
  endproperty
  a_enable_ignored: assert property (p_enable_ignored) else $error("enable taken in four-wire mode");

  property p_data_on_fall;
    (enable && $past(enable) && $changed(capture_data_out)) |-> $fell(capture_serial_clock_out);
  endproperty
  a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off a falling edge");

  property p_clock_rests;
    (state == sbs_st_idle && $past(state) == sbs_st_idle) |-> capture_serial_clock_out;
  endproperty
  a_clock_rests: assert property (p_clock_rests) else $error("serial clock not resting high");

  property p_select_level;
    (enable && state == sbs_st_shift) |-> capture_select_out == cfg[`SBS_BIT_POL];
  endproperty
  a_select_level: assert property (p_select_level) else $error("select level wrong while shifting");

  property p_gap_length;
    ($past(state) == sbs_st_gap && state == sbs_st_shift && enable) |-> $past(gap_cnt) == 3'd6;
  endproperty
  a_gap_length: assert property (p_gap_length) else $error("gap not seven clocks");

  property p_no_gap;
    (state == sbs_st_shift && !cfg[`SBS_BIT_GAP]) |=> state != sbs_st_gap;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap taken with gap bit clear");

  property p_wave_words;
    (start_burst && subset == sbs_sub_wave) |=> load_idx == 4'd0 && load_end == 4'd6;
  endproperty
  a_wave_words: assert property (p_wave_words) else $error("wave subset span wrong");

  property p_power_words;
    (start_burst && subset == sbs_sub_power) |=> load_idx == 4'd7 && load_end == 4'd15;
  endproperty
  a_power_words: assert property (p_power_words) else $error("power subset span wrong");

  property p_rsvd_subset;
    (start_burst && subset == sbs_sub_rsvd) |=> load_idx == 4'd0 && load_end == 4'd15;
  endproperty
  a_rsvd_subset: assert property (p_rsvd_subset) else $error("subset 11 not full burst");

  property p_zero_slot;
    (loading && zero_slot) |-> load_word == 32'h0000_0000;
  endproperty
  a_zero_slot: assert property (p_zero_slot) else $error("missing slot not zero");

  property p_half_period;
    (enable && state == sbs_st_shift && $changed(capture_serial_clock_out) && $past(state) == sbs_st_shift)
      |-> $past(hcnt) == half - 6'd1;
  endproperty
  a_half_period: assert property (p_half_period) else $error("serial clock half period wrong");

  c_full_burst: cover property (start_burst && subset == sbs_sub_all);
  c_gap_seen:   cover property (state == sbs_st_gap ##1 state == sbs_st_shift);
  c_tick_drop:  cover property (sample_tick_in && enable && busy);
  c_burst_end:  cover property (state == sbs_st_shift ##1 state == sbs_st_idle);
endmodule : sbs_serial_master

// ==== sbs_serial_master_tb.sv ====
// self-checking bench for the sample burst serial master
`timescale 1ns/1ps

module sbs_serial_master_tb;
  import sbs_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        setup_wr;
  logic [7:0]  setup_wdata;
  logic [7:0]  setup_rdata;
  logic        enable_wr;
  logic        enable_wdata;
  logic        enable_rdata;
  logic        four_wire;
  logic        tick;
  logic [23:0] smp [16];
  logic        sclk;
  logic        sdata;
  logic        ssel;
  logic        busy;
  logic        pol;
  logic        clear;
  int          n_bits;
  int          n_gap;
  int          n_pkt;
  int          n_bad;
  int          half_min;
  int          half_max;
  logic [31:0] words [16];
  int          n_mismatch;
  int          cmp_count;

  // variant without the neutral channel, so its slot must read zero
  sbs_serial_master #(
    .HAS_NEUTRAL  (1'b0),
    .HAS_REACTIVE (1'b1)
  ) i_dut (
    .clk_in(clk), .reset_n_in(reset_n), .setup_wr_in(setup_wr), .setup_wdata_in(setup_wdata),
    .setup_rdata_out(setup_rdata), .enable_wr_in(enable_wr), .enable_wdata_in(enable_wdata),
    .enable_rdata_out(enable_rdata), .four_wire_active_in(four_wire), .sample_tick_in(tick),
    .phase_a_current_sample_in(smp[0]), .phase_a_voltage_sample_in(smp[1]),
    .phase_b_current_sample_in(smp[2]), .phase_b_voltage_sample_in(smp[3]),
    .phase_c_current_sample_in(smp[4]), .phase_c_voltage_sample_in(smp[5]),
    .neutral_current_sample_in(smp[6]), .phase_a_apparent_power_in(smp[7]),
    .phase_b_apparent_power_in(smp[8]), .phase_c_apparent_power_in(smp[9]),
    .phase_a_active_power_in(smp[10]), .phase_b_active_power_in(smp[11]),
    .phase_c_active_power_in(smp[12]), .phase_a_reactive_power_in(smp[13]),
    .phase_b_reactive_power_in(smp[14]), .phase_c_reactive_power_in(smp[15]),
    .capture_serial_clock_out(sclk), .capture_data_out(sdata), .capture_select_out(ssel),
    .burst_busy_out(busy)
  );

  sbs_slave_model i_slave (
    .sclk_in(sclk), .data_in(sdata), .select_in(ssel), .pol_in(pol), .clear_in(clear),
    .n_bits_out(n_bits), .n_gap_out(n_gap), .n_pkt_out(n_pkt), .n_bad_out(n_bad),
    .half_min_out(half_min), .half_max_out(half_max), .words_out(words)
  );

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic wr_setup(input logic [7:0] v);
    @(posedge clk);
    setup_wr    <= 1'h1;
    setup_wdata <= v;
    @(posedge clk);
    setup_wr    <= 1'h0;
  endtask : wr_setup

  task automatic wr_enable(input logic v);
    @(posedge clk);
    enable_wr    <= 1'h1;
    enable_wdata <= v;
    @(posedge clk);
    enable_wr    <= 1'h0;
  endtask : wr_enable

  task automatic pulse_tick();
    @(posedge clk);
    tick <= 1'h1;
    @(posedge clk);
    tick <= 1'h0;
  endtask : pulse_tick

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy !== lvl && k < lim) begin
      settle(1);
      k++;
    end
    check("busy level", {31'h0, busy}, {31'h0, lvl});
  endtask : wait_busy

  // setup is written before enable so pins never show a stale polarity
  task automatic run_burst(input logic [7:0] cfg, input int first, input int nw, input int pkt,
                           input int gaps, input int half);
    logic [31:0] exp_w;
    wr_setup(cfg);
    wr_enable(1'h1);
    @(posedge clk);
    pol   <= cfg[5];
    clear <= 1'h1;
    @(posedge clk);
    clear <= 1'h0;
    pulse_tick();
    wait_busy(1'h1, 8);
    settle(200);
    pulse_tick();
    wait_busy(1'h0, 40000);
    settle(40);
    check("bit count", n_bits, nw * 32);
    for (int i = 0; i < nw; i++) begin
      exp_w = (first + i == 6) ? 32'h0000_0000 : {{8{smp[first+i][23]}}, smp[first+i]};
      check("word", words[i], exp_w);
    end
    check("gap clocks", n_gap, gaps);
    check("packages", n_pkt, nw * 32 / pkt);
    check("half min", half_min, half);
    check("half max", half_max, half);
    check("late data", n_bad, 0);
    check("idle select", {31'h0, ssel}, {31'h0, ~cfg[5]});
    check("idle clock", {31'h0, sclk}, 32'h1);
    check("busy after", {31'h0, busy}, 32'h0);
    wr_enable(1'h0);
  endtask : run_burst

  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_reset();
    check("clock rst", {31'h0, sclk}, 32'h1);
    check("data rst", {31'h0, sdata}, 32'h1);
    check("select rst", {31'h0, ssel}, 32'h1);
    check("setup rst", {24'h0, setup_rdata}, 32'h0);
    check("enable rst", {31'h0, enable_rdata}, 32'h0);
    pulse_tick();
    settle(4);
    check("busy disabled", {31'h0, busy}, 32'h0);
  endtask : sc_reset

  task automatic sc_four_wire();
    @(posedge clk);
    four_wire <= 1'h1;
    wr_enable(1'h1);
    pulse_tick();
    settle(4);
    check("enable refused", {31'h0, enable_rdata}, 32'h0);
    check("busy refused", {31'h0, busy}, 32'h0);
    @(posedge clk);
    four_wire <= 1'h0;
  endtask : sc_four_wire

  // slow rate, size bit set but ignored without gaps, reserved bits set
  task automatic sc_wave();
    run_burst(8'hcb, 0, 7, 224, 0, 128);
    check("setup readback", {24'h0, setup_rdata}, 32'h0b);
  endtask : sc_wave

  task automatic sc_power();
    run_burst(8'h36, 7, 9, 8, 245, 64);
  endtask : sc_power

  task automatic sc_full();
    run_burst(8'h1c, 0, 16, 32, 105, 64);
  endtask : sc_full

  task automatic sc_abort();
    wr_setup(8'h00);
    wr_enable(1'h1);
    pulse_tick();
    settle(3000);
    wr_enable(1'h0);
    settle(4);
    check("abort busy", {31'h0, busy}, 32'h0);
    check("abort data", {31'h0, sdata}, 32'h1);
    check("abort select", {31'h0, ssel}, 32'h1);
    check("abort clock", {31'h0, sclk}, 32'h1);
  endtask : sc_abort

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_n      = 1'h0;
    setup_wr     = 1'h0;
    setup_wdata  = 8'h00;
    enable_wr    = 1'h0;
    enable_wdata = 1'h0;
    four_wire    = 1'h0;
    tick         = 1'h0;
    pol          = 1'h0;
    clear        = 1'h0;
    n_mismatch   = 0;
    cmp_count    = 0;
    // upper half of the slots negative so sign extension shows
    for (int i = 0; i < 16; i++) smp[i] = {i[3:0], 4'h5, 16'ha5c3};
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    settle(1);
    sc_reset();
    sc_four_wire();
    sc_wave();
    sc_power();
    sc_full();
    sc_abort();
    conclude();
  end

  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule : sbs_serial_master_tb

// ==== sbs_slave_model.sv ====
// slave receiver model for the capture port: samples data on rising serial clock
`timescale 1ns/1ps

module sbs_slave_model (
  input  wire logic   sclk_in,
  input  wire logic   data_in,
  input  wire logic   select_in,
  input  wire logic   pol_in,
  input  wire logic   clear_in,
  output int          n_bits_out,
  output int          n_gap_out,
  output int          n_pkt_out,
  output int          n_bad_out,
  output int          half_min_out,
  output int          half_max_out,
  output logic [31:0] words_out [16]
);
  logic [31:0] shift;
  int          span;
  realtime     t_edge;
  realtime     t_rise;
  realtime     t_fall;
  realtime     t_data;
  realtime     t_sel;
  logic        sel_fall;

  // ****************************************
  // bookkeeping
  // ****************************************
  always @(posedge clear_in) begin
    n_bits_out   = 0;
    n_gap_out    = 0;
    n_pkt_out    = 0;
    n_bad_out    = 0;
    half_min_out = 1000000;
    half_max_out = 0;
    t_edge       = -1.0;
  end

  // first edge after a clear is skipped: the idle span before it is not a half period
  always @(sclk_in) begin
    if (t_edge >= 0.0) begin
      span = int'($realtime - t_edge);
      if (span < half_min_out) half_min_out = span;
      if (span > half_max_out) half_max_out = span;
    end
    t_edge = $realtime;
  end

  always @(select_in) begin
    t_sel = $realtime;
    if (select_in === pol_in) n_pkt_out++;
  end

  always @(data_in) t_data = $realtime;

  // select moves on the same edge as the last rise, so it is taken at the fall before
  always @(negedge sclk_in) begin
    t_fall   = $realtime;
    sel_fall = select_in;
  end

  // ****************************************
  // receive
  // ****************************************
  always @(posedge sclk_in) begin
    if (sel_fall === pol_in) begin
      if (t_data > t_rise && t_data != t_fall && t_data != t_sel) n_bad_out++;
      shift = {shift[30:0], data_in};
      n_bits_out++;
      if (n_bits_out % 32 == 0 && n_bits_out <= 512) words_out[n_bits_out / 32 - 1] = shift;
    end else begin
      n_gap_out++;
    end
    t_rise = $realtime;
  end
endmodule : sbs_slave_model
